// [common/hbss_pkg.sv]
package hbss_pkg;
   localparam int           PORT_COUNT     = 7;
   localparam int           GP_COUNT       = 4;
   localparam int           SIG_BYTES      = 4;
   localparam logic [15:0]  SIG_ADDR       = 16'hfffa;
   localparam logic [15:0]  EXEC_ADDR      = 16'h0000;
   localparam logic [31:0]  SIG_WORD       = 32'h32444655;
   localparam logic [7:0]   END_CFG_ADDR   = 8'hff;
   localparam logic [7:0]   GP_DIR_ADDR    = 8'h00;
   localparam logic [7:0]   GP_PULL_EN_ADDR = 8'h01;
   localparam logic [7:0]   GP_PULL_UP_ADDR = 8'h02;
   localparam logic [7:0]   GP_OUT_ADDR    = 8'h03;
   localparam logic [7:0]   GP_IN_ADDR     = 8'h04;
   localparam logic [7:0]   DEF_NONREM     = 8'h00;
   localparam logic [7:0]   DEF_CHARGE     = 8'h00;
   localparam logic [2:0]   MODE_SLAVE_MGMT = 3'h1;
   localparam logic [2:0]   MODE_SPI       = 3'h2;
   localparam int           PLL_WAIT_CYC   = 16;
   localparam int           SPI_DIV        = 2;
   localparam logic [GP_COUNT-1:0] GP_RESET = '0;
   typedef enum logic [3:0] {
      ST_PLL_WAIT,
      ST_ROM_PROBE,
      ST_DEFAULT_LOAD,
      ST_STRAP_READ,
      ST_EXT_CONFIG,
      ST_FUSE_MERGE,
      ST_CHARGER_DETECT,
      ST_CONNECT,
      ST_IDLE
   } hbss_stage_t;
endpackage

// [rtl/hbss_spi_probe.sv]
`timescale 1ns/1ps
module hbss_spi_probe
   import hbss_pkg::*;
(
   input  wire logic        sys_clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   input  wire logic        start_i,
   input  wire logic        miso_i,
   output logic             done_o,
   output logic             match_o,
   output logic             sck_o,
   output logic             cs_n_o,
   output logic             mosi_o
);
   // single-bit read, mode 0: command 03h, 16-bit address, 32 data bits
   localparam int TOTAL = 8 + 16 + 32 + 1;
   logic [55:0] shift_out;
   logic [31:0] shift_in;
   logic [6:0]  bit_cnt;
   logic        busy;
   logic        miso_q1;
   logic        miso_q2;

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         miso_q1 <= 1'b0;
         miso_q2 <= 1'b0;
      end else if (ce_i) begin
         miso_q1 <= miso_i;
         miso_q2 <= miso_q1;
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         busy      <= 1'b0;
         cs_n_o    <= 1'b1;
         sck_o     <= 1'b0;
         mosi_o    <= 1'b0;
         bit_cnt   <= '0;
         shift_out <= '0;
         shift_in  <= '0;
         done_o    <= 1'b0;
         match_o   <= 1'b0;
      end else if (ce_i) begin
         done_o <= 1'b0;
         if (start_i && !busy && !done_o) begin
            busy      <= 1'b1;
            cs_n_o    <= 1'b0;
            bit_cnt   <= '0;
            shift_out <= {8'h03, SIG_ADDR, 32'h0000_0000};
            mosi_o    <= 1'b0;
         end else if (busy) begin
            if (!sck_o) begin
               sck_o  <= 1'b1;
               // two-flop lag on miso: the spare clock catches the last bit
               shift_in <= {shift_in[30:0], miso_q2};
            end else begin
               sck_o     <= 1'b0;
               shift_out <= {shift_out[54:0], 1'b0};
               mosi_o    <= shift_out[54];
               bit_cnt   <= bit_cnt + 7'h01;
               if (bit_cnt == 7'(TOTAL - 1)) begin
                  busy    <= 1'b0;
                  cs_n_o  <= 1'b1;
                  done_o  <= 1'b1;
                  match_o <= (shift_in == SIG_WORD);
               end
            end
         end
      end
   end
endmodule

// [rtl/hbss_boot_seq.sv]
// Summary of operation
// - two disable straps per port 7..1
// - port off only when both straps high
// - legacy disable also kills superspeed path
// - fixed-port strap decodes to port mask
// - charge strap decodes to port mask
// - general pins in/out with pulls
// - general pin settings in writable registers
// - reset low standby, high hub boot
// - standby disables ports, floats data pins
// - no configuration kept across standby
// - release enters probe after pll lock
// - signature at fffa selects external code
// - non-spi mode skips flash probe
// - single-bit mode 0 flash transfers
// - defaults loaded then strap override
// - straps latched at release, test mgmt pull-ups
// - slave mode with both pull-ups enters external config
// - external config waits with no timeout
// - slave setting enables mgmt slave
// - charge detect or connect after merge
`timescale 1ns/1ps
module hbss_boot_seq
   import hbss_pkg::*;
(
   input  wire logic                   sys_clk_i,
   input  wire logic                   rst_i,
   input  wire logic                   ce_i,
   input  wire logic                   chip_reset_n_i,
   input  wire logic                   pll_lock_i,
   input  wire logic                   bus_power_i,
   input  wire logic [PORT_COUNT-1:0]  port_dplus_off_strap_i,
   input  wire logic [PORT_COUNT-1:0]  port_dminus_off_strap_i,
   input  wire logic [2:0]             fixed_port_count_strap_i,
   input  wire logic [2:0]             charge_port_count_strap_i,
   input  wire logic [2:0]             mode_strap_i,
   input  wire logic                   mgmt_data_pin_i,
   input  wire logic                   mgmt_clock_pin_i,
   input  wire logic                   mgmt_wr_i,
   input  wire logic [7:0]             mgmt_addr_i,
   input  wire logic [7:0]             mgmt_wdata_i,
   input  wire logic                   spi_miso_i,
   input  wire logic [GP_COUNT-1:0]    general_pin_i,
   output logic [GP_COUNT-1:0]         general_pin_o,
   output logic [GP_COUNT-1:0]         general_pin_oe_n_o,
   output logic [GP_COUNT-1:0]         general_pull_en_o,
   output logic [GP_COUNT-1:0]         general_pull_up_o,
   output logic [7:0]                  mgmt_rdata_o,
   output logic                        mgmt_slave_en_o,
   output logic [PORT_COUNT-1:0]       port_legacy_en_o,
   output logic [PORT_COUNT-1:0]       port_super_en_o,
   output logic [PORT_COUNT-1:0]       port_fixed_o,
   output logic [PORT_COUNT-1:0]       port_charge_o,
   output logic                        data_pins_hiz_o,
   output logic                        pll_run_o,
   output logic                        ext_exec_o,
   output hbss_pkg::hbss_stage_t       stage_o,
   output logic                        spi_sck_o,
   output logic                        spi_cs_n_o,
   output logic                        spi_mosi_o
);
   function automatic logic [PORT_COUNT-1:0] level_mask(
      input logic [2:0] code);
      logic [PORT_COUNT-1:0] m;
      m = '0;
      unique case (code)
         3'h0:    m = 7'h00;
         3'h1:    m = 7'h01;
         3'h2:    m = 7'h03;
         3'h3:    m = 7'h07;
         3'h4:    m = 7'h0f;
         3'h5:    m = 7'h7f;
         default: m = 7'h00;
      endcase
      return m;
   endfunction

   hbss_stage_t stage;
   hbss_stage_t next_stage;
   logic        rst_n_q1;
   logic        rst_n_q2;
   logic        mdat_q1;
   logic        mdat_q2;
   logic        mclk_q1;
   logic        mclk_q2;
   logic [GP_COUNT-1:0] gin_q1;
   logic [GP_COUNT-1:0] gin_q2;
   logic [$clog2(PLL_WAIT_CYC+1)-1:0] lock_cnt;
   logic        straps_taken;
   logic [PORT_COUNT-1:0] dplus_off;
   logic [PORT_COUNT-1:0] dminus_off;
   logic [2:0]  fixed_code;
   logic [2:0]  charge_code;
   logic [2:0]  mode_code;
   logic [PORT_COUNT-1:0] fixed_cfg;
   logic [PORT_COUNT-1:0] charge_cfg;
   logic        probe_start;
   logic        probe_done;
   logic        probe_match;
   logic [GP_COUNT-1:0] gp_dir;
   logic        cfg_end;
   logic        standby;

   // the pin reset is asynchronous to the core clock
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rst_n_q1 <= 1'b0;
         rst_n_q2 <= 1'b0;
         mdat_q1  <= 1'b0;
         mdat_q2  <= 1'b0;
         mclk_q1  <= 1'b0;
         mclk_q2  <= 1'b0;
         gin_q1   <= '0;
         gin_q2   <= '0;
      end else if (ce_i) begin
         rst_n_q1 <= chip_reset_n_i;
         rst_n_q2 <= rst_n_q1;
         mdat_q1  <= mgmt_data_pin_i;
         mdat_q2  <= mdat_q1;
         mclk_q1  <= mgmt_clock_pin_i;
         mclk_q2  <= mclk_q1;
         gin_q1   <= general_pin_i;
         gin_q2   <= gin_q1;
      end
   end

   assign standby = !rst_n_q2;
   assign cfg_end = mgmt_wr_i && (mgmt_addr_i == END_CFG_ADDR);
   assign probe_start = (stage == ST_ROM_PROBE) && (mode_code == MODE_SPI);

   always_comb begin
      next_stage = stage;
      unique case (stage)
         ST_PLL_WAIT:
            if (lock_cnt == PLL_WAIT_CYC[$bits(lock_cnt)-1:0])
               next_stage = ST_ROM_PROBE;
         ST_ROM_PROBE:
            if (mode_code != MODE_SPI)
               next_stage = ST_DEFAULT_LOAD;
            else if (probe_done)
               next_stage = probe_match ? ST_IDLE : ST_DEFAULT_LOAD;
         ST_DEFAULT_LOAD:
            next_stage = ST_STRAP_READ;
         ST_STRAP_READ:
            if (mode_code == MODE_SLAVE_MGMT && mdat_q2 && mclk_q2)
               next_stage = ST_EXT_CONFIG;
            else
               next_stage = ST_FUSE_MERGE;
         ST_EXT_CONFIG:
            if (cfg_end)
               next_stage = ST_FUSE_MERGE;
         ST_FUSE_MERGE:
            if (bus_power_i)
               next_stage = (charge_cfg != '0) ? ST_CHARGER_DETECT
                                               : ST_CONNECT;
         ST_CHARGER_DETECT:
            next_stage = ST_CONNECT;
         ST_CONNECT:
            next_stage = ST_CONNECT;
         ST_IDLE:
            next_stage = ST_IDLE;
         default:
            next_stage = ST_PLL_WAIT;
      endcase
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         stage    <= ST_PLL_WAIT;
         lock_cnt <= '0;
      end else if (ce_i) begin
         if (standby) begin
            stage    <= ST_PLL_WAIT;
            lock_cnt <= '0;
         end else begin
            stage <= next_stage;
            // lock must hold steadily; a drop restarts the wait
            if (stage == ST_PLL_WAIT)
               lock_cnt <= pll_lock_i ? lock_cnt + 1'b1 : '0;
         end
      end
   end

   // straps are captured once per release, never while standing by
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         straps_taken <= 1'b0;
         dplus_off    <= '0;
         dminus_off   <= '0;
         fixed_code   <= '0;
         charge_code  <= '0;
         mode_code    <= '0;
      end else if (ce_i) begin
         if (standby) begin
            straps_taken <= 1'b0;
         end else if (!straps_taken) begin
            straps_taken <= 1'b1;
            dplus_off    <= port_dplus_off_strap_i;
            dminus_off   <= port_dminus_off_strap_i;
            fixed_code   <= fixed_port_count_strap_i;
            charge_code  <= charge_port_count_strap_i;
            mode_code    <= mode_strap_i;
         end
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         fixed_cfg  <= DEF_NONREM[PORT_COUNT-1:0];
         charge_cfg <= DEF_CHARGE[PORT_COUNT-1:0];
      end else if (ce_i) begin
         if (standby) begin
            fixed_cfg  <= DEF_NONREM[PORT_COUNT-1:0];
            charge_cfg <= DEF_CHARGE[PORT_COUNT-1:0];
         end else if (stage == ST_ROM_PROBE) begin
            fixed_cfg  <= DEF_NONREM[PORT_COUNT-1:0];
            charge_cfg <= DEF_CHARGE[PORT_COUNT-1:0];
         end else if (stage == ST_DEFAULT_LOAD) begin
            fixed_cfg  <= level_mask(fixed_code);
            charge_cfg <= level_mask(charge_code);
         end
      end
   end

   // general pins: controller owns direction, pulls and level
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         gp_dir            <= GP_RESET;
         general_pin_o     <= GP_RESET;
         general_pull_en_o <= GP_RESET;
         general_pull_up_o <= GP_RESET;
         mgmt_rdata_o      <= '0;
      end else if (ce_i) begin
         if (standby) begin
            gp_dir            <= GP_RESET;
            general_pin_o     <= GP_RESET;
            general_pull_en_o <= GP_RESET;
            general_pull_up_o <= GP_RESET;
            mgmt_rdata_o      <= '0;
         end else begin
            if (mgmt_slave_en_o && mgmt_wr_i) begin
               unique case (mgmt_addr_i)
                  GP_DIR_ADDR:     gp_dir <= mgmt_wdata_i[GP_COUNT-1:0];
                  GP_PULL_EN_ADDR:
                     general_pull_en_o <= mgmt_wdata_i[GP_COUNT-1:0];
                  GP_PULL_UP_ADDR:
                     general_pull_up_o <= mgmt_wdata_i[GP_COUNT-1:0];
                  GP_OUT_ADDR:
                     general_pin_o <= mgmt_wdata_i[GP_COUNT-1:0];
                  default: ;
               endcase
            end
            unique case (mgmt_addr_i)
               GP_DIR_ADDR:     mgmt_rdata_o <= 8'(gp_dir);
               GP_PULL_EN_ADDR: mgmt_rdata_o <= 8'(general_pull_en_o);
               GP_PULL_UP_ADDR: mgmt_rdata_o <= 8'(general_pull_up_o);
               GP_OUT_ADDR:     mgmt_rdata_o <= 8'(general_pin_o);
               GP_IN_ADDR:      mgmt_rdata_o <= 8'(gin_q2);
               default:         mgmt_rdata_o <= 8'h00;
            endcase
         end
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         general_pin_oe_n_o <= '1;
      end else if (ce_i) begin
         general_pin_oe_n_o <= standby ? '1 : ~gp_dir;
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         mgmt_slave_en_o  <= 1'b0;
         port_legacy_en_o <= '0;
         port_super_en_o  <= '0;
         port_fixed_o     <= '0;
         port_charge_o    <= '0;
         data_pins_hiz_o  <= 1'b1;
         pll_run_o        <= 1'b0;
         ext_exec_o       <= 1'b0;
         stage_o          <= ST_PLL_WAIT;
      end else if (ce_i) begin
         stage_o   <= stage;
         pll_run_o <= !standby;
         mgmt_slave_en_o <= !standby && straps_taken
                            && (mode_code == MODE_SLAVE_MGMT);
         if (standby) begin
            port_legacy_en_o <= '0;
            port_super_en_o  <= '0;
            data_pins_hiz_o  <= 1'b1;
            ext_exec_o       <= 1'b0;
         end else begin
            if (stage == ST_ROM_PROBE && probe_done && probe_match)
               ext_exec_o <= 1'b1;
            data_pins_hiz_o  <= !(stage == ST_CONNECT);
            port_legacy_en_o <= ~(dplus_off & dminus_off);
            port_super_en_o  <= ~(dplus_off & dminus_off);
            port_fixed_o     <= fixed_cfg;
            port_charge_o    <= charge_cfg;
         end
      end
   end

   hbss_spi_probe u_probe (
      .sys_clk_i (sys_clk_i),
      .rst_i     (rst_i | standby),
      .ce_i      (ce_i),
      .start_i   (probe_start),
      .miso_i    (spi_miso_i),
      .done_o    (probe_done),
      .match_o   (probe_match),
      .sck_o     (spi_sck_o),
      .cs_n_o    (spi_cs_n_o),
      .mosi_o    (spi_mosi_o)
   );

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);

   sequence s_in_ext;
      ce_i && !standby && stage == ST_EXT_CONFIG;
   endsequence
   sequence s_merge_next;
      ##1 stage == ST_FUSE_MERGE;
   endsequence

   a_port_off_both: assert property (
      ce_i && !standby ##1 1 |->
      port_legacy_en_o == ~($past(dplus_off) & $past(dminus_off)))
      else $error("port enable mismatch");
   a_super_follows: assert property (
      port_super_en_o == port_legacy_en_o)
      else $error("superspeed path differs");
   a_standby_off: assert property (
      ce_i && standby |=> port_legacy_en_o == '0 && data_pins_hiz_o)
      else $error("ports alive in standby");
   a_ext_end: assert property (
      s_in_ext and cfg_end |-> s_merge_next)
      else $error("end write ignored");
   a_ext_hold: assert property (
      s_in_ext and !cfg_end |=> stage == ST_EXT_CONFIG)
      else $error("external config left early");
   a_strap_route: assert property (
      ce_i && !standby && stage == ST_STRAP_READ
      && !(mode_code == MODE_SLAVE_MGMT && mdat_q2 && mclk_q2)
      |=> stage == ST_FUSE_MERGE)
      else $error("bad strap branch");
   a_skip_probe: assert property (
      ce_i && !standby && stage == ST_ROM_PROBE && mode_code != MODE_SPI
      |=> stage == ST_DEFAULT_LOAD)
      else $error("probe not skipped");
   a_standby_pll: assert property (
      ce_i && standby |=> !pll_run_o && stage == ST_PLL_WAIT)
      else $error("standby not entered");
endmodule

// [sim/hbss_flash_model.sv]
`timescale 1ns/1ps
module hbss_flash_model (
   input  wire logic        sck_i,
   input  wire logic        cs_n_i,
   input  wire logic        mosi_i,
   input  wire logic [31:0] word_i,
   output logic             miso_o,
   output logic             hit_o
);
   logic [31:0] sh;
   logic [31:0] dat;
   logic        send;
   initial begin
      sh = '0;
      dat = '0;
      send = 1'b0;
      miso_o = 1'b0;
      hit_o = 1'b0;
   end
   // size and clock rate not modelled, fitted parts must meet them
   // mode 0, single bit: command and address taken on rising sck
   always @(posedge sck_i) begin
      if (!cs_n_i && !send) begin
         sh = {sh[30:0], mosi_i};
         // read command at the signature offset, 16 or 24 bit address
         if (sh[23:0] == 24'h03fffa || sh == 32'h0300fffa) begin
            send = 1'b1;
            hit_o = 1'b1;
            dat = word_i;
         end
      end
   end
   // data changes on falling sck; undriven line toggles so no stale bit
   always @(negedge sck_i) begin
      if (!cs_n_i && send) begin
         miso_o = dat[31];
         dat = {dat[30:0], 1'b0};
      end else begin
         miso_o = ~miso_o;
      end
   end
   always @(negedge cs_n_i) begin
      hit_o = 1'b0;
   end
   always @(posedge cs_n_i) begin
      send = 1'b0;
      sh = '0;
      miso_o = ~miso_o;
   end
endmodule

// [sim/hub_boot_strap_sequencer_tb.sv]
`timescale 1ns/1ps
module hub_boot_strap_sequencer_tb;
   import hbss_pkg::*;
   logic                  sys_clk_i;
   logic                  rst_i;
   logic                  chip_reset_n;
   logic                  bus_power;
   logic [PORT_COUNT-1:0] dp_strap;
   logic [PORT_COUNT-1:0] dm_strap;
   logic [2:0]            fixed_code;
   logic [2:0]            charge_code;
   logic [2:0]            mode_code;
   logic                  data_pull;
   logic                  clock_pull;
   logic                  mgmt_wr;
   logic [7:0]            mgmt_addr;
   logic [7:0]            mgmt_wdata;
   logic [7:0]            rdata;
   logic [GP_COUNT-1:0]   gp_ext;
   logic [GP_COUNT-1:0]   gp_in;
   logic [GP_COUNT-1:0]   gp_out;
   logic [GP_COUNT-1:0]   gp_oe_n;
   logic [GP_COUNT-1:0]   pull_en;
   logic [GP_COUNT-1:0]   pull_up;
   logic [PORT_COUNT-1:0] legacy_en;
   logic [PORT_COUNT-1:0] super_en;
   logic [PORT_COUNT-1:0] fixed_mask;
   logic [PORT_COUNT-1:0] charge_mask;
   logic                  slave_en;
   logic                  hiz;
   logic                  pll_run;
   logic                  ext_exec;
   logic                  sck;
   logic                  cs_n;
   logic                  mosi;
   logic                  miso;
   logic                  hit;
   logic [31:0]           rom_word;
   hbss_stage_t           stage;
   hbss_stage_t           seen[$];
   hbss_stage_t           want[$];
   int                    err_total;
   int                    tests_run;
   int                    cycles = 0;
   // driven pins read back what they drive, the rest what the board drives
   assign gp_in = (gp_out & ~gp_oe_n) | (gp_ext & gp_oe_n);
   hbss_boot_seq DUT (
      .sys_clk_i                 (sys_clk_i),
      .rst_i                     (rst_i),
      .ce_i                      (1'b1),
      .chip_reset_n_i            (chip_reset_n),
      .pll_lock_i                (1'b1),
      .bus_power_i               (bus_power),
      .port_dplus_off_strap_i    (dp_strap),
      .port_dminus_off_strap_i   (dm_strap),
      .fixed_port_count_strap_i  (fixed_code),
      .charge_port_count_strap_i (charge_code),
      .mode_strap_i              (mode_code),
      .mgmt_data_pin_i           (data_pull),
      .mgmt_clock_pin_i          (clock_pull),
      .mgmt_wr_i                 (mgmt_wr),
      .mgmt_addr_i               (mgmt_addr),
      .mgmt_wdata_i              (mgmt_wdata),
      .spi_miso_i                (miso),
      .general_pin_i             (gp_in),
      .general_pin_o             (gp_out),
      .general_pin_oe_n_o        (gp_oe_n),
      .general_pull_en_o         (pull_en),
      .general_pull_up_o         (pull_up),
      .mgmt_rdata_o              (rdata),
      .mgmt_slave_en_o           (slave_en),
      .port_legacy_en_o          (legacy_en),
      .port_super_en_o           (super_en),
      .port_fixed_o              (fixed_mask),
      .port_charge_o             (charge_mask),
      .data_pins_hiz_o           (hiz),
      .pll_run_o                 (pll_run),
      .ext_exec_o                (ext_exec),
      .stage_o                   (stage),
      .spi_sck_o                 (sck),
      .spi_cs_n_o                (cs_n),
      .spi_mosi_o                (mosi)
   );
   hbss_flash_model rom (
      .sck_i  (sck),
      .cs_n_i (cs_n),
      .mosi_i (mosi),
      .word_i (rom_word),
      .miso_o (miso),
      .hit_o  (hit)
   );
   initial begin
      sys_clk_i = 1'b0;
      forever #12.5 sys_clk_i = ~sys_clk_i;
   end
   always @(stage) begin
      if (!rst_i && stage != ST_PLL_WAIT) begin
         seen.push_back(stage);
      end
   end
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // the whole run needs about a thousand cycles
   always @(posedge sys_clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_total++;
         close_out();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string what);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got,
                  exp);
      end
   endtask
   task automatic chk_order();
      tests_run++;
      if (seen != want) begin
         err_total++;
         $display("CHECK FAILED t=%0t stage order, %0d seen", $time,
                  seen.size());
      end
   endtask
   function automatic logic [PORT_COUNT-1:0] lvl(input logic [2:0] c);
      case (c)
         3'h0: return 7'h00;
         3'h1: return 7'h01;
         3'h2: return 7'h03;
         3'h3: return 7'h07;
         3'h4: return 7'h0f;
         3'h5: return 7'h7f;
         default: return 7'h00;
      endcase
   endfunction
   task automatic wait_stage(input hbss_stage_t s, input int lim);
      int n;
      n = 0;
      while (stage !== s && n < lim) begin
         @(negedge sys_clk_i);
         n++;
      end
      chk(32'(stage), 32'(s), "stage reached");
   endtask
   // straps are set while in standby, then the chip reset pin is released
   task automatic boot(input logic [2:0] md, input logic [2:0] fc,
                       input logic [2:0] cc, input logic pd, input logic pc);
      @(negedge sys_clk_i);
      chip_reset_n = 1'b0;
      mode_code = md;
      fixed_code = fc;
      charge_code = cc;
      data_pull = pd;
      clock_pull = pc;
      repeat (4) @(negedge sys_clk_i);
      seen.delete();
      chip_reset_n = 1'b1;
   endtask
   task automatic mgmt_write(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk_i);
      mgmt_wr = 1'b1;
      mgmt_addr = a;
      mgmt_wdata = d;
      @(negedge sys_clk_i);
      mgmt_wr = 1'b0;
   endtask
   // pin inputs pass a two-flop sync before the read register
   task automatic mgmt_read(input logic [7:0] a, output logic [7:0] d);
      @(negedge sys_clk_i);
      mgmt_addr = a;
      repeat (5) @(negedge sys_clk_i);
      d = rdata;
   endtask
   task automatic t_decode();
      logic [2:0]            cc;
      logic [PORT_COUNT-1:0] en;
      hbss_stage_t           fin;
      bus_power = 1'b1;
      for (int i = 0; i < 8; i++) begin
         cc = 3'(7 - i);
         dp_strap = 7'h35 ^ 7'(i);
         dm_strap = 7'h1e ^ 7'(i << 2);
         en = ~(dp_strap & dm_strap);
         fin = (lvl(cc) != 7'h00) ? ST_CHARGER_DETECT : ST_CONNECT;
         boot(3'h0, 3'(i), cc, 1'b1, 1'b1);
         wait_stage(fin, 100);
         want = {ST_ROM_PROBE, ST_DEFAULT_LOAD, ST_STRAP_READ,
                 ST_FUSE_MERGE, fin};
         chk_order();
         chk(32'(hit), 32'h0, "flash probed");
         chk(32'(legacy_en), 32'(en), "legacy enables");
         chk(32'(super_en), 32'(en), "super enables");
         chk(32'(fixed_mask), 32'(lvl(3'(i))), "fixed mask");
         chk(32'(charge_mask), 32'(lvl(cc)), "charge mask");
         chk(32'(slave_en), 32'h0, "slave enable");
         dp_strap = ~dp_strap;
         fixed_code = ~fixed_code;
         charge_code = ~charge_code;
         repeat (4) @(negedge sys_clk_i);
         chk(32'(legacy_en), 32'(en), "legacy held");
         chk(32'(fixed_mask), 32'(lvl(3'(i))), "fixed held");
         chk(32'(charge_mask), 32'(lvl(cc)), "charge held");
      end
   endtask
   task automatic t_ext_config();
      logic [7:0] d;
      dp_strap = '0;
      dm_strap = '0;
      boot(MODE_SLAVE_MGMT, 3'h0, 3'h0, 1'b1, 1'b0);
      wait_stage(ST_CONNECT, 100);
      chk_order();
      boot(MODE_SLAVE_MGMT, 3'h0, 3'h0, 1'b1, 1'b1);
      wait_stage(ST_EXT_CONFIG, 100);
      chk(32'(slave_en), 32'h1, "slave enable");
      gp_ext = 4'hc;
      mgmt_write(GP_DIR_ADDR, 8'h03);
      mgmt_write(GP_OUT_ADDR, 8'h01);
      mgmt_write(GP_PULL_EN_ADDR, 8'h0c);
      mgmt_write(GP_PULL_UP_ADDR, 8'h04);
      @(negedge sys_clk_i);
      chk(32'(gp_oe_n), 32'hc, "pin directions");
      chk(32'(gp_out), 32'h1, "pin levels");
      chk(32'(pull_en), 32'hc, "pull enables");
      chk(32'(pull_up), 32'h4, "pull polarity");
      mgmt_read(GP_DIR_ADDR, d);
      chk(32'(d[3:0]), 32'h3, "direction readback");
      mgmt_read(GP_IN_ADDR, d);
      chk(32'(d[3:0]), 32'hd, "pin input readback");
      repeat (300) @(negedge sys_clk_i);
      chk(32'(stage), 32'(ST_EXT_CONFIG), "still configuring");
      mgmt_write(END_CFG_ADDR, 8'h00);
      wait_stage(ST_CONNECT, 50);
      want = {ST_ROM_PROBE, ST_DEFAULT_LOAD, ST_STRAP_READ, ST_EXT_CONFIG,
              ST_FUSE_MERGE, ST_CONNECT};
      chk_order();
   endtask
   task automatic t_standby();
      @(negedge sys_clk_i);
      chip_reset_n = 1'b0;
      repeat (4) @(negedge sys_clk_i);
      chk(32'(legacy_en), 32'h0, "ports off");
      chk(32'(super_en), 32'h0, "super ports off");
      chk(32'(hiz), 32'h1, "data pins float");
      chk(32'(pll_run), 32'h0, "pll halted");
      chk(32'(gp_oe_n), 32'hf, "pins released");
      chk(32'(stage), 32'(ST_PLL_WAIT), "standby stage");
      boot(3'h0, 3'h0, 3'h0, 1'b0, 1'b0);
      wait_stage(ST_CONNECT, 100);
      chk(32'(hiz), 32'h0, "data pins active");
      chk(32'(gp_oe_n), 32'hf, "directions cleared");
      chk(32'(pull_en), 32'h0, "pulls cleared");
      chk(32'(legacy_en), 32'h7f, "ports on");
      mgmt_write(GP_DIR_ADDR, 8'h0f);
      repeat (2) @(negedge sys_clk_i);
      chk(32'(gp_oe_n), 32'hf, "write refused");
   endtask
   task automatic t_spi();
      rom_word = SIG_WORD ^ 32'h1;
      boot(MODE_SPI, 3'h0, 3'h0, 1'b0, 1'b0);
      wait_stage(ST_CONNECT, 1000);
      chk(32'(hit), 32'h1, "signature read");
      chk(32'(ext_exec), 32'h0, "internal code");
      want = {ST_ROM_PROBE, ST_DEFAULT_LOAD, ST_STRAP_READ,
              ST_FUSE_MERGE, ST_CONNECT};
      chk_order();
      rom_word = SIG_WORD;
      boot(MODE_SPI, 3'h0, 3'h0, 1'b0, 1'b0);
      wait_stage(ST_IDLE, 1000);
      chk(32'(hit), 32'h1, "signature read");
      chk(32'(ext_exec), 32'h1, "external code");
      want = {ST_ROM_PROBE, ST_IDLE};
      chk_order();
   endtask
   initial begin
      rst_i = 1'b1;
      chip_reset_n = 1'b0;
      bus_power = 1'b0;
      dp_strap = '0;
      dm_strap = '0;
      fixed_code = 3'h0;
      charge_code = 3'h0;
      mode_code = 3'h0;
      data_pull = 1'b0;
      clock_pull = 1'b0;
      mgmt_wr = 1'b0;
      mgmt_addr = 8'h00;
      mgmt_wdata = 8'h00;
      gp_ext = 4'h0;
      rom_word = 32'h0;
      err_total = 0;
      tests_run = 0;
      repeat (4) @(negedge sys_clk_i);
      rst_i = 1'b0;
      t_decode();
      t_ext_config();
      t_standby();
      t_spi();
      close_out();
   end
endmodule
